// ===== rtl/mft_pkg.sv
// Shared constants and types of the multi-function timer flag and contention logic.
package mft_pkg;
  localparam int          NCH       = 5;
  localparam int          CW        = 16;
  localparam int          NCC       = 4;
  localparam int          NFL       = 6;
  // Per-channel register offsets; channel n sits at n * 0x40.
  localparam logic [2:0]  SEL_CNT   = 3'h0;
  localparam logic [2:0]  SEL_CC0   = 3'h1;
  localparam logic [2:0]  SEL_CTRL  = 3'h5;
  localparam logic [2:0]  SEL_STAT  = 3'h6;
  localparam logic [2:0]  SEL_IEN   = 3'h7;
  // Global registers.
  localparam logic [11:0] ADR_START = 12'h140;
  localparam logic [11:0] ADR_DEAD  = 12'h144;
  localparam logic [11:0] ADR_MSTOP = 12'h148;
  // Control register fields.
  localparam int          CB_CLR    = 0;
  localparam int          CB_DOWN   = 1;
  localparam int          CB_BUF    = 2;
  localparam int          CB_CLK    = 3;
  localparam int          CB_CASC   = 5;
  localparam int          CB_C1CAP  = 6;
  localparam int          CB_BSRC   = 7;
  localparam int          CB_CAPEN  = 8;
  localparam int          CB_CPWM   = 12;
  localparam int          CTRL_W    = 13;
  // Status bit positions: 0..3 match/capture, then overflow, underflow.
  localparam int          SB_OVF    = 4;
  localparam int          SB_UNF    = 5;
  // Count clock sources.
  localparam logic [1:0]  CLK_INT   = 2'h0;
  localparam logic [1:0]  CLK_RISE  = 2'h1;
  localparam logic [1:0]  CLK_FALL  = 2'h2;
  // Reset values and the up-count maximum.
  localparam logic [15:0] CNT_RST   = 16'h0000;
  localparam logic [15:0] CNT_MAX   = 16'hffff;
  localparam logic        MSTOP_RST = 1'b1;
  typedef enum logic [1:0] {
    MFT_OKAY   = 2'h0,
    MFT_SLVERR = 2'h2
  } mft_resp_t;
endpackage

// ===== rtl/mft_cnt_if.sv
// Control and event bundle between the timer core and one channel counter.
`timescale 1ns/1ps
`default_nettype none
interface mft_cnt_if;
  logic        tick;
  logic        dec;
  logic        clr;
  logic        wr;
  logic [15:0] wdata;
  logic        load;
  logic [15:0] load_val;
  logic [15:0] cnt;
  logic        ovf;
  logic        unf;
  modport ctl  (output tick, dec, clr, wr, wdata, load, load_val, input cnt, ovf, unf);
  modport core (input tick, dec, clr, wr, wdata, load, load_val, output cnt, ovf, unf);
endinterface
`default_nettype wire

// ===== rtl/mft_counter.sv
// One 16-bit channel counter with clear, load, write and count priorities.
`timescale 1ns/1ps
`default_nettype none
module mft_counter (
  input wire logic clk,
  input wire logic reset_n,
  mft_cnt_if.core  c
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        wrap;

  // A wrap only flags when no clear, load or bus write overrides the count.
  assign wrap  = c.tick & (c.dec ? (cnt_r == mft_pkg::CNT_RST) : (cnt_r == mft_pkg::CNT_MAX));
  assign c.ovf = wrap & ~c.dec & ~c.wr & ~c.clr & ~c.load;
  assign c.unf = wrap & c.dec & ~c.wr & ~c.clr & ~c.load;
  assign c.cnt = cnt_r;

  // Clear beats a write, and a write beats a count step.
  always_comb
  begin
    if (c.clr)
      cnt_nxt = mft_pkg::CNT_RST;
    else if (c.load)
      cnt_nxt = c.load_val;
    else if (c.wr)
      cnt_nxt = c.wdata;
    else if (c.tick)
      cnt_nxt = c.dec ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
    else
      cnt_nxt = cnt_r;
  end

  // Counter state.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      cnt_r <= mft_pkg::CNT_RST;
    else
      cnt_r <= cnt_nxt;
  end
endmodule
`default_nettype wire

// ===== rtl/mft_flag.sv
// One status flag with read-one-then-write-zero clearing and its interrupt gate.
`timescale 1ns/1ps
`default_nettype none
module mft_flag (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic set,
  input  wire logic rd_seen,
  input  wire logic wr_zero,
  input  wire logic auto_clr,
  input  wire logic en,
  output logic      flag,
  output logic      irq
);
  logic flag_r;
  logic armed_r;
  logic clr;

  assign clr  = (wr_zero & armed_r) | auto_clr;
  assign flag = flag_r;
  assign irq  = flag_r & en;

  // A new event wins over any clear in the same cycle.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      flag_r <= 1'b0;
    else if (set)
      flag_r <= 1'b1;
    else if (clr)
      flag_r <= 1'b0;
  end

  // Arming remembers that software has seen the flag as one.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      armed_r <= 1'b0;
    else if (!flag_r || (clr && !set))
      armed_r <= 1'b0;
    else if (rd_seen)
      armed_r <= 1'b1;
  end
endmodule
`default_nettype wire

// ===== rtl/mft_timer.sv
// Five-channel timer core with status flags, contention priorities and AXI4-Lite registers.
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Flag clears by write zero after read one
// - Transfer acknowledge clears its flag automatically
// - Unit starts stopped; registers locked until released
// - Clear on match gives period N plus one
// - Counter clear beats a counter write
// - Counter write beats a count step
// - Compare write and match both take effect
// - Buffer transfer: channel 0 new, 3/4 old
// - Read during capture returns captured value
// - Capture beats compare register write
// - Capture buffer transfer beats buffer write
// - Channel 2 write suppresses cascade count
// - Channel 1 compare A still matches
// - Channel 0 still captures on channel 1 clock
// - Channel 1 register B still captures
// - Complementary stop loads dead time and zero
// - Complementary restart resumes from loaded values
// - Match or capture sets flag, raises request; with buffering on channels 0, 3 and 4, registers C and D set no flag
// - Overflow sets flag, raises request
// - Underflow past zero sets flag, raises request
// - Request is flag and enable together
// - One match per counter input clock
module mft_timer (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [4:0]  ext_count_clk,
  input  wire logic [19:0] timer_io_pin,
  input  wire logic [4:0]  xfer_ack,
  output logic [19:0]      match_capture_irq,
  output logic [4:0]       overflow_irq,
  output logic [4:0]       underflow_irq
);
  localparam int NCH = mft_pkg::NCH;

  // ****************************************************************
  // Register bus decode
  // ****************************************************************
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;
  logic        wr_go;
  logic        ar_go;
  logic        mstop_r;
  logic [4:0]  start_r;
  logic [15:0] dead_r;
  logic [31:0] wmask;
  logic        w_in_ch;
  logic        r_in_ch;
  logic        w_ok;
  logic        r_ok;
  logic        cp_stop;
  logic [4:0]  cpwm_v;
  logic [4:0]  clk_req;
  logic [4:0]  wrap_req;
  logic [4:0]  ev_a;
  logic [31:0] rd_word [NCH];

  // Both write channels are taken together, one write in flight at a time.
  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
  assign s_axi_wready  = s_axi_awready;
  assign s_axi_arready = ~rvalid_r;
  assign wr_go = s_axi_awready;
  assign ar_go = s_axi_arvalid & ~rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp  = rresp_r;
  assign s_axi_rdata  = rdata_r;
  assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

  // Channel window is the first five 64-byte blocks.
  assign w_in_ch = (s_axi_awaddr[11:9] == 3'h0) && (s_axi_awaddr[8:6] < 3'h5);
  assign r_in_ch = (s_axi_araddr[11:9] == 3'h0) && (s_axi_araddr[8:6] < 3'h5);

  // module stop lock
  // While stopped only the stop register answers; the rest report an error.
  assign w_ok = (s_axi_awaddr[1:0] == 2'h0) &&
                ((s_axi_awaddr == mft_pkg::ADR_MSTOP) ||
                 (!mstop_r && (w_in_ch || s_axi_awaddr == mft_pkg::ADR_START ||
                               s_axi_awaddr == mft_pkg::ADR_DEAD)));
  assign r_ok = (s_axi_araddr[1:0] == 2'h0) &&
                ((s_axi_araddr == mft_pkg::ADR_MSTOP) ||
                 (!mstop_r && (r_in_ch || s_axi_araddr == mft_pkg::ADR_START ||
                               s_axi_araddr == mft_pkg::ADR_DEAD)));

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] nw,
                                          input logic [31:0] m);
    merge16 = (old & ~m[15:0]) | (nw[15:0] & m[15:0]);
  endfunction

  // Write response.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= mft_pkg::MFT_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= w_ok ? mft_pkg::MFT_OKAY : mft_pkg::MFT_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  // Read data is registered at the address handshake, so a capture in that
  // cycle is already visible in the returned word.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rvalid_r <= 1'b0;
      rresp_r  <= mft_pkg::MFT_OKAY;
      rdata_r  <= 32'h0000_0000;
    end
    else if (ar_go)
    begin
      rvalid_r <= 1'b1;
      rresp_r  <= r_ok ? mft_pkg::MFT_OKAY : mft_pkg::MFT_SLVERR;
      if (!r_ok)
        rdata_r <= 32'h0000_0000;
      else if (r_in_ch)
        rdata_r <= rd_word[s_axi_araddr[8:6]];
      else if (s_axi_araddr == mft_pkg::ADR_START)
        rdata_r <= {27'h0, start_r};
      else if (s_axi_araddr == mft_pkg::ADR_DEAD)
        rdata_r <= {16'h0, dead_r};
      else
        rdata_r <= {31'h0, mstop_r};
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  // ****************************************************************
  // Global registers
  // ****************************************************************
  // complementary stop detect
  assign cp_stop = wr_go && w_ok && (s_axi_awaddr == mft_pkg::ADR_START) &&
                   s_axi_wstrb[0] && start_r[3] && !s_axi_wdata[3] && cpwm_v[3];

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      mstop_r <= mft_pkg::MSTOP_RST;
      start_r <= 5'h00;
      dead_r  <= mft_pkg::CNT_RST;
    end
    else if (wr_go && w_ok)
    begin
      if (s_axi_awaddr == mft_pkg::ADR_MSTOP && s_axi_wstrb[0])
        mstop_r <= s_axi_wdata[0];
      if (s_axi_awaddr == mft_pkg::ADR_START && s_axi_wstrb[0])
        start_r <= s_axi_wdata[4:0];
      if (s_axi_awaddr == mft_pkg::ADR_DEAD)
        dead_r <= merge16(dead_r, s_axi_wdata, wmask);
    end
  end

  // ****************************************************************
  // Channels
  // ****************************************************************
  mft_cnt_if cif [NCH] ();

  for (genvar g = 0; g < NCH; g++)
  begin : gch
    logic [15:0] cc_r [4];
    logic [12:0] ctrl_r;
    logic [5:0]  ien_r;
    logic [5:0]  ev_r;
    logic [5:0]  flag;
    logic [3:0]  pin_d_r;
    logic        ext_d_r;
    logic        ext_ev;
    logic        run;
    logic        tick;
    logic        casc_ct;
    logic        bufok;
    logic        hit;
    logic [7:0]  wsel;
    logic [3:0]  cap;
    logic [3:0]  mt;
    logic [3:0]  capen;
    logic [3:0]  pin_rise;
    logic        ext_rise;
    logic        ext_fall;

    assign hit   = wr_go && w_ok && w_in_ch && (s_axi_awaddr[8:6] == 3'(g));
    assign wsel  = hit ? (8'h01 << s_axi_awaddr[4:2]) : 8'h00;
    assign capen = ctrl_r[mft_pkg::CB_CAPEN +: 4];
    assign bufok = ctrl_r[mft_pkg::CB_BUF] && (g == 0 || g == 3 || g == 4);
    assign run   = start_r[g] & ~mstop_r;
    assign cpwm_v[g] = ctrl_r[mft_pkg::CB_CPWM];
    assign pin_rise  = timer_io_pin[g*4 +: 4] & ~pin_d_r;
    assign ext_rise  = ext_count_clk[g] & ~ext_d_r;
    assign ext_fall  = ~ext_count_clk[g] & ext_d_r;

    // Count clock source; the pin edges rely on the documented pulse widths.
    // single or both edges
    always_comb
    begin
      case (ctrl_r[mft_pkg::CB_CLK +: 2])
        mft_pkg::CLK_INT:  ext_ev = 1'b1;
        mft_pkg::CLK_RISE: ext_ev = ext_rise;
        mft_pkg::CLK_FALL: ext_ev = ext_fall;
        default:           ext_ev = ext_rise | ext_fall;
      endcase
    end

    // cascade count suppressed
    // Channel 2 reports no wrap when its counter is being written.
    if (g == 1)
    begin : gcasc
      assign clk_req[g] = run & (ctrl_r[mft_pkg::CB_CASC] ? wrap_req[2] : ext_ev);
      assign tick = run & (ctrl_r[mft_pkg::CB_CASC] ? (cif[2].ovf | cif[2].unf) : ext_ev);
      assign casc_ct = run & ctrl_r[mft_pkg::CB_CASC] & wrap_req[2] & cif[2].wr;
    end
    else
    begin : gown
      assign clk_req[g] = run & ext_ev;
      assign tick = run & ext_ev;
      assign casc_ct = 1'b0;
    end

    assign wrap_req[g] = tick & (ctrl_r[mft_pkg::CB_DOWN] ?
                         (cif[g].cnt == mft_pkg::CNT_RST) : (cif[g].cnt == mft_pkg::CNT_MAX));

    for (genvar k = 0; k < 4; k++)
    begin : gk
      assign mt[k] = ~capen[k] & (cif[g].cnt == cc_r[k]) & (tick | ((k == 0) & casc_ct));
      assign cap[k] = capen[k] & (
        ((g == 1 && k == 1 && ctrl_r[mft_pkg::CB_BSRC]) ? ev_a[0] : pin_rise[k]) |
        ((g == 0) & ctrl_r[mft_pkg::CB_C1CAP] & clk_req[1]));
    end
    assign ev_a[g] = mt[0] | cap[0];

    assign cif[g].tick  = tick;
    assign cif[g].dec   = ctrl_r[mft_pkg::CB_DOWN];
    assign cif[g].clr   = ctrl_r[mft_pkg::CB_CLR] & mt[0];
    assign cif[g].wr    = wsel[mft_pkg::SEL_CNT];
    assign cif[g].wdata = merge16(cif[g].cnt, s_axi_wdata, wmask);
    assign cif[g].load  = cp_stop & (g == 3 || g == 4);
    assign cif[g].load_val = (g == 3) ? dead_r : mft_pkg::CNT_RST;

    mft_counter u_cnt (
      .clk     (clk),
      .reset_n (reset_n),
      .c       (cif[g])
    );

    // Edge history and events; flags follow their event by one edge.
    // one edge after the update
    always_ff @(posedge clk)
    begin
      if (!reset_n)
      begin
        pin_d_r <= 4'h0;
        ext_d_r <= 1'b0;
        ev_r    <= 6'h00;
      end
      else
      begin
        pin_d_r <= timer_io_pin[g*4 +: 4];
        ext_d_r <= ext_count_clk[g];
        ev_r    <= {cif[g].unf, cif[g].ovf, (mt[3] | cap[3]) & ~bufok,
                    (mt[2] | cap[2]) & ~bufok, mt[1] | cap[1], mt[0] | cap[0]};
      end
    end

    // Control and enable registers.
    always_ff @(posedge clk)
    begin
      if (!reset_n)
      begin
        ctrl_r <= 13'h0000;
        ien_r  <= 6'h00;
      end
      else
      begin
        if (wsel[mft_pkg::SEL_CTRL] && s_axi_wstrb[0])
          ctrl_r[7:0] <= s_axi_wdata[7:0];
        if (wsel[mft_pkg::SEL_CTRL] && s_axi_wstrb[1])
          ctrl_r[12:8] <= s_axi_wdata[12:8];
        if (wsel[mft_pkg::SEL_IEN] && s_axi_wstrb[0])
          ien_r <= s_axi_wdata[5:0];
      end
    end

    // Compare/capture registers; on channels 0, 3 and 4 register C doubles as buffer of register A.
    always_ff @(posedge clk)
    begin
      if (!reset_n)
      begin
        for (int k = 0; k < 4; k++)
          cc_r[k] <= mft_pkg::CNT_RST;
      end
      else
      begin
        for (int k = 0; k < 4; k++)
        begin
          if (cap[k])
            cc_r[k] <= cif[g].cnt;
          else if (k == 2 && bufok && cap[0])
            cc_r[k] <= cc_r[0];
          else if (k == 0 && bufok && mt[0])
            cc_r[k] <= (g == 0 && wsel[mft_pkg::SEL_CC0 + 3'h2]) ?
                       merge16(cc_r[2], s_axi_wdata, wmask) : cc_r[2];
          else if (wsel[mft_pkg::SEL_CC0 + 3'(k)])
            cc_r[k] <= merge16(cc_r[k], s_axi_wdata, wmask);
        end
      end
    end

    always_comb
    begin
      case (s_axi_araddr[4:2])
        mft_pkg::SEL_CNT:  rd_word[g] = {16'h0, cif[g].cnt};
        mft_pkg::SEL_CTRL: rd_word[g] = {19'h0, ctrl_r};
        mft_pkg::SEL_STAT: rd_word[g] = {26'h0, flag};
        mft_pkg::SEL_IEN:  rd_word[g] = {26'h0, ien_r};
        default:
          rd_word[g] = {16'h0, cap[s_axi_araddr[3:2] - 2'h1] ? cif[g].cnt :
                                cc_r[s_axi_araddr[3:2] - 2'h1]};
      endcase
    end

    for (genvar j = 0; j < mft_pkg::NFL; j++)
    begin : gfl
      logic irq;
      mft_flag u_flag (
        .clk      (clk),
        .reset_n  (reset_n),
        .set      (ev_r[j]),
        .rd_seen  (ar_go && r_ok && r_in_ch && s_axi_araddr[8:6] == 3'(g) &&
                   s_axi_araddr[4:2] == mft_pkg::SEL_STAT),
        .wr_zero  (wsel[mft_pkg::SEL_STAT] && s_axi_wstrb[0] && !s_axi_wdata[j]),
        .auto_clr (j == 0 && xfer_ack[g]),
        .en       (ien_r[j]),
        .flag     (flag[j]),
        .irq      (irq)
      );
      if (j < 4)
      begin : gmc
        assign match_capture_irq[g*4 + j] = irq;
      end
      else if (j == mft_pkg::SB_OVF)
      begin : gov
        assign overflow_irq[g] = irq;
      end
      else
      begin : gun
        assign underflow_irq[g] = irq;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/mft_xfer_model.sv
// Transfer controller model that answers channel register A requests.
`timescale 1ns/1ps
`default_nettype none
module mft_xfer_model (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        enable,
  input  wire logic        slow,
  input  wire logic [19:0] match_capture_irq,
  output logic [4:0]       xfer_ack
);
  logic [4:0] req;
  logic [4:0] seen_r;
  logic [4:0] pend_r;
  // The register A request of each channel sits at bit ch*4.
  assign req = {match_capture_irq[16], match_capture_irq[12], match_capture_irq[8],
                match_capture_irq[4], match_capture_irq[0]};
  // acknowledge clears flag
  // Only a fresh request is answered, so a held request never starts a second transfer.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      seen_r   <= 5'h00;
      pend_r   <= 5'h00;
      xfer_ack <= 5'h00;
    end
    else
    begin
      seen_r   <= req;
      pend_r   <= req & ~seen_r;
      xfer_ack <= enable ? (slow ? pend_r : (req & ~seen_r)) : 5'h00;
    end
  end
endmodule
`default_nettype wire

// ===== verification/mft_timer_checker.sv
// Concurrent checks of the timer's register bus and its access lock.
`timescale 1ns/1ps
`default_nettype none
module mft_timer_checker (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  logic stop_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence wr_take;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  endsequence
  sequence rd_take;
    s_axi_arvalid && !s_axi_rvalid;
  endsequence
  // Mirror of the stop bit, since the lock is not visible at the ports.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      stop_r <= 1'b1;
    else if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && s_axi_wstrb[0]
             && s_axi_awaddr == mft_pkg::ADR_MSTOP)
      stop_r <= s_axi_wdata[0];
  end
  aw_ready_a: assert property (s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid))
    else $error("write ready wrong");
  ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read ready wrong");
  wr_resp_a: assert property (wr_take |=> s_axi_bvalid)
    else $error("write response late");
  rd_resp_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  lock_read_a: assert property (rd_take ##0 (stop_r && s_axi_araddr != mft_pkg::ADR_MSTOP)
    |=> s_axi_rresp == mft_pkg::MFT_SLVERR && s_axi_rdata == 32'h0) else $error("locked read");
  lock_write_a: assert property (wr_take ##0 (stop_r && s_axi_awaddr != mft_pkg::ADR_MSTOP)
    |=> s_axi_bresp == mft_pkg::MFT_SLVERR) else $error("locked write");
endmodule
bind mft_timer mft_timer_checker i_mft_timer_checker (.*);
`default_nettype wire

// ===== verification/test_mft_timer.sv
// Self-checking bench of the timer flags, lock and counter stop values.
`timescale 1ns/1ps
`default_nettype none
module test_mft_timer;
  logic        clk, reset_n, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready;
  logic        awready, wready, arready, ack_en, slow;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rd_r, wr_r;
  logic [4:0]  xfer_ack, ovf, unf, ext;
  logic [19:0] mci, pin;
  int          num_errors = 0, comparisons = 0, cyc = 0, n, k, t, prev;
  mft_timer i_mft_timer (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ext_count_clk(ext), .timer_io_pin(pin),
    .xfer_ack(xfer_ack), .match_capture_irq(mci), .overflow_irq(ovf), .underflow_irq(unf));
  mft_xfer_model i_mft_xfer_model (.clk(clk), .reset_n(reset_n), .enable(ack_en),
    .slow(slow), .match_capture_irq(mci), .xfer_ack(xfer_ack));
  // ********
  // Helpers
  // ********
  function automatic logic [11:0] ra(input int ch, input logic [2:0] sel);
    return 12'(ch * 64) | {7'h00, sel, 2'h0};
  endfunction
  function automatic int period(input int nv);
    return nv + 1;
  endfunction
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  // Address and data are offered together and held until taken.
  task automatic wr(logic [11:0] a, logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge clk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    wr_r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    rd_v = rdata;
    rd_r = rresp;
    rready <= 1'b0;
  endtask
  task automatic summarize();
    if (num_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ********
  // Clock, timeout and sequence
  // ********
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // The whole sequence needs under a thousand cycles; a hang is cut well after that.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      num_errors++;
      summarize();
    end
  end
  initial
  begin
    {reset_n, awvalid, wvalid, bready, arvalid, rready, ack_en, slow} = 8'h00;
    {awaddr, araddr, wdata, wstrb} = {24'h0, 32'h0, 4'hf};
    {ext, pin} = 25'h0;
    void'($urandom(32'h9d0c));
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    wr(mft_pkg::ADR_START, 1);
    chk("locked bresp", wr_r, mft_pkg::MFT_SLVERR);
    rd(ra(0, mft_pkg::SEL_CNT));
    chk("locked rdata", rd_v, 0);
    chk("locked rresp", rd_r, mft_pkg::MFT_SLVERR);
    wr(mft_pkg::ADR_MSTOP, 0);
    rd(mft_pkg::ADR_MSTOP);
    chk("stop rresp", rd_r, mft_pkg::MFT_OKAY);
    chk("stop bit", rd_v, 0);
    // Clear on match with random compare value; the partner clears each flag.
    n = 3 + $urandom % 8;
    wr(ra(0, mft_pkg::SEL_CC0), n);
    wr(ra(0, mft_pkg::SEL_CTRL), 1 << mft_pkg::CB_CLR);
    wr(ra(0, mft_pkg::SEL_IEN), 1);
    ack_en <= 1'b1;
    slow <= 1'($urandom % 2);
    wr(mft_pkg::ADR_START, 1);
    {k, t, prev} = 0;
    for (int i = 0; i < 120 && k < 3; i++)
    begin
      @(posedge clk);
      if (mci[0] === 1'b1 && prev == 0)
      begin
        k++;
        if (k > 1)
          chk("match period", i - t, period(n));
        t = i;
      end
      prev = int'(mci[0]);
    end
    chk("match requests", k, 3);
    // Software clear needs a prior read of one; an acknowledge still in flight
    // would clear the flag behind our back, so let it drain first.
    ack_en <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 40 && mci[0] !== 1'b1; i++) @(posedge clk);
    wr(mft_pkg::ADR_START, 0);
    wr(ra(0, mft_pkg::SEL_STAT), 0);
    chk("flag unread", mci[0], 1);
    rd(ra(0, mft_pkg::SEL_STAT));
    chk("flag read", rd_v[0], 1);
    wr(ra(0, mft_pkg::SEL_STAT), 0);
    @(posedge clk);
    chk("flag cleared", mci[0], 0);
    // Overflow, underflow and a flag set with its request disabled.
    n = 2 + $urandom % 8;
    wr(ra(1, mft_pkg::SEL_CNT), 32'hffff - n);
    wr(ra(2, mft_pkg::SEL_CTRL), 1 << mft_pkg::CB_DOWN);
    wr(ra(2, mft_pkg::SEL_CNT), n);
    wr(ra(4, mft_pkg::SEL_CNT), 32'hfffe);
    wr(ra(1, mft_pkg::SEL_IEN), 1 << mft_pkg::SB_OVF);
    wr(ra(2, mft_pkg::SEL_IEN), 1 << mft_pkg::SB_UNF);
    wr(mft_pkg::ADR_START, 5'h16);
    repeat (20) @(posedge clk);
    chk("overflow irq", ovf, 5'h02);
    chk("underflow irq", unf, 5'h04);
    rd(ra(4, mft_pkg::SEL_STAT));
    chk("ch4 status", rd_v[5:4], 2'h1);
    // Complementary stop values with a random dead time.
    n = $urandom % 65536;
    wr(mft_pkg::ADR_DEAD, n);
    wr(ra(3, mft_pkg::SEL_CTRL), 1 << mft_pkg::CB_CPWM);
    wr(mft_pkg::ADR_START, 5'h08);
    repeat (5) @(posedge clk);
    wr(mft_pkg::ADR_START, 0);
    rd(ra(3, mft_pkg::SEL_CNT));
    chk("ch3 stop count", rd_v, n);
    rd(ra(4, mft_pkg::SEL_CNT));
    chk("ch4 stop count", rd_v, 0);
    // External rising-edge count on channel 0, then a pin edge captures into register B.
    n = 1 + $urandom % 6;
    wr(ra(0, mft_pkg::SEL_CNT), 0);
    wr(ra(0, mft_pkg::SEL_CTRL), (1 << mft_pkg::CB_CLK) | (1 << (mft_pkg::CB_CAPEN + 1)));
    wr(mft_pkg::ADR_START, 1);
    for (int i = 0; i < n; i++)
    begin
      ext[0] <= 1'b1;
      repeat (3) @(posedge clk);
      ext[0] <= 1'b0;
      repeat (3) @(posedge clk);
    end
    pin[1] <= 1'b1;
    repeat (3) @(posedge clk);
    rd(ra(0, mft_pkg::SEL_CC0 + 3'h1));
    chk("capture b", rd_v, n);
    rd(ra(0, mft_pkg::SEL_STAT));
    chk("capture flag", rd_v[1], 1);
    summarize();
  end
endmodule
`default_nettype wire
